// ==== shared/wvip_pkg.sv ====
package wvip_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] WVIP_OFF_WIN_START = 8'h00;
	localparam logic [7:0] WVIP_OFF_WIN_END = 8'h04;
	localparam logic [7:0] WVIP_OFF_CTRL = 8'h08;
	localparam logic [7:0] WVIP_OFF_IRQ_EN = 8'h0c;
	localparam logic [7:0] WVIP_OFF_PEND = 8'h10;
	localparam logic [7:0] WVIP_OFF_STATUS = 8'h14;
	localparam logic [7:0] WVIP_OFF_SNAP = 8'h18;
	localparam logic [7:0] WVIP_OFF_GRANT = 8'h1c;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int WVIP_BIT_EXT1 = 1;
	localparam int WVIP_BIT_EXT2 = 2;
	localparam int WVIP_BIT_NMI = 8;
	localparam int WVIP_BIT_HOST = 9;
	localparam int WVIP_BIT_RASTER = 10;
	localparam int WVIP_BIT_WFAULT = 11;
	localparam int WVIP_BIT_BADOP = 30;
	localparam int WVIP_ST_OUTSIDE = 0;
	localparam int WVIP_ST_GIE = 1;
	localparam int WVIP_ST_OUTCODE = 2;
	localparam logic [31:0] WVIP_EN_MASK = 32'h00000e06;
	localparam logic [31:0] WVIP_PEND_MASK = 32'h40000f06;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] WVIP_RST_WIN = 32'h00000000;
	localparam logic [1:0] WVIP_RST_MODE = 2'h0;
	localparam logic [31:0] WVIP_RST_EN = 32'h00000000;

	// ----------------------------------------------------------------
	// vectors: base plus index times a 32-byte step
	// ----------------------------------------------------------------
	localparam logic [31:0] WVIP_VEC_BASE = 32'hfffffc00;
	localparam int WVIP_VEC_STEP = 32;
	localparam int WVIP_NUM_SRC = 8;
	localparam logic [4:0] WVIP_VIDX_RESET = 5'h1f;
	localparam logic [4:0] WVIP_VIDX_NMI = 5'h17;
	localparam logic [4:0] WVIP_VIDX_HOST = 5'h16;
	localparam logic [4:0] WVIP_VIDX_RASTER = 5'h15;
	localparam logic [4:0] WVIP_VIDX_WFAULT = 5'h14;
	localparam logic [4:0] WVIP_VIDX_EXT1 = 5'h1e;
	localparam logic [4:0] WVIP_VIDX_EXT2 = 5'h1d;
	localparam logic [4:0] WVIP_VIDX_BADOP = 5'h01;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WVIP_MODE_OFF = 2'h0,
		WVIP_MODE_HIT = 2'h1,
		WVIP_MODE_MISS = 2'h2,
		WVIP_MODE_CLIP = 2'h3
	} wvip_mode_t;

	typedef enum logic [1:0] {
		WVIP_OP_LINE = 2'h0,
		WVIP_OP_BLOCK = 2'h1,
		WVIP_OP_FILL = 2'h2,
		WVIP_OP_POINT = 2'h3
	} wvip_op_t;

	typedef enum logic [1:0] {
		WVIP_ARB_IDLE = 2'b00,
		WVIP_ARB_OFFER = 2'b01,
		WVIP_ARB_GAP = 2'b11
	} wvip_arb_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		wvip_op_t op;
		logic [15:0] x;
		logic [15:0] y;
	} wvip_pix_t;

	typedef struct packed {
		logic take;
		logic [2:0] source;
		logic [31:0] vector;
	} wvip_grant_t;

endpackage

// ==== design/wvip_win_cmp.sv ====
`timescale 1ns/10ps
module wvip_win_cmp (
	// point
	input wire logic [15:0] x_i,
	input wire logic [15:0] y_i,
	// window limits
	input wire logic [15:0] x_start_i,
	input wire logic [15:0] y_start_i,
	input wire logic [15:0] x_end_i,
	input wire logic [15:0] y_end_i,
	// result
	output logic inside_o,
	output logic [3:0] outcode_o
);
	// all four edges compared at once; an empty window sets some bit
	// for every point, so it never reports inside
	always_comb begin
		outcode_o[3] = (x_i < x_start_i);
		outcode_o[2] = (x_i > x_end_i);
		outcode_o[1] = (y_i < y_start_i);
		outcode_o[0] = (y_i > y_end_i);
		inside_o = (outcode_o == 4'h0);
	end
endmodule

// ==== design/wvip_top.sv ====
`timescale 1ns/10ps
// Summary of operation
// R1: hit mode: write attempt inside window sets window fault pending.
// R2: miss mode: write attempt outside window sets window fault pending.
// R3: window fault taken only when its enable and global enable are 1.
// R4: masked fault still updates outside flag and pending flag.
// R5: on window fault, datapath registers freeze at intermediate values.
// R6: clip mode checks every pixel against four edges, no added time.
// R7: postclip suppresses memory write of a pixel outside the window.
// R8: point compare yields 4-bit region code, zero when inside.
// R9: miss mode line drawing terminates when it crosses the boundary.
// R10: eight interrupt sources, reset included.
// R11: 32 vectors from fffffc00, each a 32-bit routine address.
// R12: priority reset, nmi, host, raster, window, ext1, ext2, bad opcode.
// R13: simultaneous requests: highest enabled priority served first.
// R14: reset and unmaskable nmi ignore every enable bit.
// R15: reset is taken after the reset input returns high.
// R16: ext requests come from pins; all others are internal.
// R17: illegal opcode raises lowest-priority bad opcode trap.
// R18: inside means start <= coordinate <= end on both axes.
// R19: with checking on, outside attempt sets outside flag, inside clears.
// R20: window fault enable is bit 11 of irq enable register.
// R21: window fault pending is bit 11 of pending register.
// R22: window fault pending stays set until software clears it.
module wvip_top (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// drawing datapath
	input wire wvip_pkg::wvip_pix_t pix_req_i,
	input wire logic [31:0] work_state_i,
	output logic pix_write_o,
	output logic line_abort_o,
	output logic freeze_o,
	output logic window_outside_o,
	// point compare
	input wire logic cmp_valid_i,
	input wire logic [15:0] cmp_x_i,
	input wire logic [15:0] cmp_y_i,
	output logic cmp_done_o,
	output logic [3:0] outcode_o,
	// request sources
	input wire logic global_irq_enable_i,
	input wire logic nmi_set_i,
	input wire logic host_request_irq_i,
	input wire logic raster_row_irq_i,
	input wire logic ext_request_one_b_i,
	input wire logic ext_request_two_b_i,
	input wire logic bad_opcode_trap_i,
	// core handshake
	input wire logic irq_ack_i,
	output wvip_pkg::wvip_grant_t grant_o
);
	import wvip_pkg::*;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0] win_start, next_win_start;
	logic [31:0] win_end, next_win_end;
	wvip_mode_t mode, next_mode;
	logic [31:0] irq_enable_reg, next_irq_enable_reg;
	logic [31:0] snapshot, next_snapshot;
	logic [31:0] next_reg_rdata;
	logic sw_clear;
	logic [31:0] clear_bits;
	assign sw_clear = reg_wr_i && (reg_addr_i == WVIP_OFF_PEND);
	assign clear_bits = sw_clear ? reg_wdata_i : 32'h00000000;
	always_comb begin
		next_win_start = win_start;
		next_win_end = win_end;
		next_mode = mode;
		next_irq_enable_reg = irq_enable_reg;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				WVIP_OFF_WIN_START: next_win_start = reg_wdata_i;
				WVIP_OFF_WIN_END: next_win_end = reg_wdata_i;
				WVIP_OFF_CTRL: next_mode = wvip_mode_t'(reg_wdata_i[1:0]);
				WVIP_OFF_IRQ_EN: next_irq_enable_reg =
					reg_wdata_i & WVIP_EN_MASK; // R20
				default: ;
			endcase
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			win_start <= WVIP_RST_WIN;
			win_end <= WVIP_RST_WIN;
			mode <= wvip_mode_t'(WVIP_RST_MODE);
			irq_enable_reg <= WVIP_RST_EN;
		end else begin
			win_start <= next_win_start;
			win_end <= next_win_end;
			mode <= next_mode;
			irq_enable_reg <= next_irq_enable_reg;
		end
	end

	// ----------------------------------------------------------------
	// window comparators
	// ----------------------------------------------------------------
	logic pix_inside;
	logic [3:0] cmp_code;
	wvip_win_cmp u_pix_cmp (
		.x_i(pix_req_i.x), .y_i(pix_req_i.y),
		.x_start_i(win_start[15:0]), .y_start_i(win_start[31:16]),
		.x_end_i(win_end[15:0]), .y_end_i(win_end[31:16]),
		.inside_o(pix_inside), // R18
		.outcode_o()
	);
	wvip_win_cmp u_point_cmp (
		.x_i(cmp_x_i), .y_i(cmp_y_i),
		.x_start_i(win_start[15:0]), .y_start_i(win_start[31:16]),
		.x_end_i(win_end[15:0]), .y_end_i(win_end[31:16]),
		.inside_o(),
		.outcode_o(cmp_code)
	);

	// ----------------------------------------------------------------
	// pixel checking
	// ----------------------------------------------------------------
	logic fault;
	logic next_pix_write, next_line_abort, next_outside;
	logic next_cmp_done;
	logic [3:0] next_outcode;
	always_comb begin
		fault = 1'b0;
		next_pix_write = 1'b0;
		next_line_abort = 1'b0;
		next_outside = window_outside_o;
		next_snapshot = snapshot;
		next_cmp_done = cmp_valid_i;
		next_outcode = cmp_valid_i ? cmp_code : outcode_o; // R8
		if (pix_req_i.valid) begin
			unique case (mode)
				WVIP_MODE_OFF: next_pix_write = 1'b1;
				WVIP_MODE_HIT: fault = pix_inside; // R1
				WVIP_MODE_MISS: begin
					fault = !pix_inside; // R2
					next_pix_write = pix_inside;
				end
				WVIP_MODE_CLIP: next_pix_write = pix_inside; // R6 R7
			endcase
			if (mode != WVIP_MODE_OFF) begin
				next_outside = !pix_inside; // R19 R4
			end
			// lines stop at the fault whether or not it is enabled
			next_line_abort = fault && (pix_req_i.op == WVIP_OP_LINE); // R9
			if (fault) begin
				next_snapshot = work_state_i; // R5
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pix_write_o <= 1'b0;
			line_abort_o <= 1'b0;
			freeze_o <= 1'b0;
			window_outside_o <= 1'b0;
			snapshot <= 32'h00000000;
			cmp_done_o <= 1'b0;
			outcode_o <= 4'h0;
		end else begin
			pix_write_o <= next_pix_write;
			line_abort_o <= next_line_abort;
			freeze_o <= fault; // R5
			window_outside_o <= next_outside;
			snapshot <= next_snapshot;
			cmp_done_o <= next_cmp_done;
			outcode_o <= next_outcode;
		end
	end

	// ----------------------------------------------------------------
	// pending flags
	// ----------------------------------------------------------------
	logic [31:0] pending_flags_reg, next_pending;
	logic reset_pend, next_reset_pend;
	logic ack_nmi, ack_badop;
	always_comb begin
		next_pending = pending_flags_reg & ~(clear_bits & WVIP_PEND_MASK);
		next_pending[WVIP_BIT_EXT1] = !ext_request_one_b_i; // R16
		next_pending[WVIP_BIT_EXT2] = !ext_request_two_b_i; // R16
		if (ack_nmi) begin
			next_pending[WVIP_BIT_NMI] = 1'b0;
		end
		if (ack_badop) begin
			next_pending[WVIP_BIT_BADOP] = 1'b0;
		end
		// sets are applied last so they win over a same-cycle clear
		if (nmi_set_i) begin
			next_pending[WVIP_BIT_NMI] = 1'b1;
		end
		if (host_request_irq_i) begin
			next_pending[WVIP_BIT_HOST] = 1'b1;
		end
		if (raster_row_irq_i) begin
			next_pending[WVIP_BIT_RASTER] = 1'b1;
		end
		if (fault) begin
			next_pending[WVIP_BIT_WFAULT] = 1'b1; // R21 R22
		end
		if (bad_opcode_trap_i) begin
			next_pending[WVIP_BIT_BADOP] = 1'b1; // R17
		end
		next_reset_pend = reset_pend && !(irq_ack_i
			&& grant_o.source == 3'h0);
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			pending_flags_reg <= 32'h00000000;
			reset_pend <= 1'b1; // R15
		end else begin
			pending_flags_reg <= next_pending;
			reset_pend <= next_reset_pend;
		end
	end

	// ----------------------------------------------------------------
	// priority arbiter
	// ----------------------------------------------------------------
	logic [WVIP_NUM_SRC-1:0] req;
	logic gie;
	localparam logic [4:0] VIDX [WVIP_NUM_SRC] = '{WVIP_VIDX_RESET,
		WVIP_VIDX_NMI, WVIP_VIDX_HOST, WVIP_VIDX_RASTER, WVIP_VIDX_WFAULT,
		WVIP_VIDX_EXT1, WVIP_VIDX_EXT2, WVIP_VIDX_BADOP};
	assign gie = global_irq_enable_i;
	assign ack_nmi = irq_ack_i && grant_o.take && grant_o.source == 3'h1;
	assign ack_badop = irq_ack_i && grant_o.take
		&& grant_o.source == 3'h7;
	// index order is priority order, 0 highest
	always_comb begin
		req[0] = reset_pend; // R14
		req[1] = pending_flags_reg[WVIP_BIT_NMI]; // R14
		req[2] = pending_flags_reg[WVIP_BIT_HOST] && gie
			&& irq_enable_reg[WVIP_BIT_HOST];
		req[3] = pending_flags_reg[WVIP_BIT_RASTER] && gie
			&& irq_enable_reg[WVIP_BIT_RASTER];
		req[4] = pending_flags_reg[WVIP_BIT_WFAULT] && gie
			&& irq_enable_reg[WVIP_BIT_WFAULT]; // R3
		req[5] = pending_flags_reg[WVIP_BIT_EXT1] && gie
			&& irq_enable_reg[WVIP_BIT_EXT1];
		req[6] = pending_flags_reg[WVIP_BIT_EXT2] && gie
			&& irq_enable_reg[WVIP_BIT_EXT2];
		req[7] = pending_flags_reg[WVIP_BIT_BADOP];
	end
	logic win_any;
	logic [2:0] win_src;
	wvip_arb_t arb, next_arb;
	wvip_grant_t next_grant;
	always_comb begin
		win_any = 1'b0;
		win_src = 3'h0;
		for (int i = WVIP_NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				win_any = 1'b1; // R10 R12 R13
				win_src = 3'(i);
			end
		end
	end
	always_comb begin
		next_arb = arb;
		next_grant = grant_o;
		unique case (arb)
			WVIP_ARB_IDLE: begin
				if (win_any) begin
					next_arb = WVIP_ARB_OFFER;
					next_grant.take = 1'b1;
					next_grant.source = win_src;
					next_grant.vector = WVIP_VEC_BASE
						+ 32'(VIDX[win_src]) * 32'(WVIP_VEC_STEP); // R11
				end
			end
			WVIP_ARB_OFFER: begin
				if (irq_ack_i) begin
					next_arb = WVIP_ARB_GAP;
					next_grant.take = 1'b0;
				end
			end
			WVIP_ARB_GAP: next_arb = WVIP_ARB_IDLE;
			default: begin
				next_arb = WVIP_ARB_IDLE;
				next_grant.take = 1'b0;
			end
		endcase
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			arb <= WVIP_ARB_IDLE;
			grant_o <= '0;
		end else begin
			arb <= next_arb;
			grant_o <= next_grant;
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_comb begin
		next_reg_rdata = 32'h00000000;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				WVIP_OFF_WIN_START: next_reg_rdata = win_start;
				WVIP_OFF_WIN_END: next_reg_rdata = win_end;
				WVIP_OFF_CTRL: next_reg_rdata = {30'h0, mode};
				WVIP_OFF_IRQ_EN: next_reg_rdata = irq_enable_reg;
				WVIP_OFF_PEND: next_reg_rdata = pending_flags_reg;
				WVIP_OFF_STATUS: begin
					next_reg_rdata[WVIP_ST_OUTSIDE] = window_outside_o;
					next_reg_rdata[WVIP_ST_GIE] = gie;
					next_reg_rdata[WVIP_ST_OUTCODE +: 4] = outcode_o;
				end
				WVIP_OFF_SNAP: next_reg_rdata = snapshot;
				WVIP_OFF_GRANT: next_reg_rdata = grant_o.vector;
				default: next_reg_rdata = 32'h00000000;
			endcase
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 32'h00000000;
		end else begin
			reg_rdata_o <= next_reg_rdata;
		end
	end

endmodule

// ==== tb/wvip_core_model.sv ====
`timescale 1ns/10ps
module wvip_core_model (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// grant side
	input wire logic take_i,
	input wire logic slow_i,
	output logic irq_ack_o
);
	logic [1:0] cnt;

	// ------------------------------------------------------------
	// core takes an offer at once, or after three waiting cycles
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			cnt <= 2'h0;
			irq_ack_o <= 1'b0;
		end else if (take_i && !irq_ack_o) begin
			irq_ack_o <= (cnt == (slow_i ? 2'h3 : 2'h0));
			cnt <= cnt + 2'h1;
		end else begin
			cnt <= 2'h0;
			irq_ack_o <= 1'b0;
		end
	end
endmodule

// ==== tb/wvip_checker.sv ====
`timescale 1ns/10ps
module wvip_checker (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	// watched ports
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire wvip_pkg::wvip_pix_t pix_req_i,
	input wire logic pix_write_o,
	input wire logic line_abort_o,
	input wire logic freeze_o,
	input wire logic window_outside_o,
	input wire logic cmp_valid_i,
	input wire logic cmp_done_o,
	input wire logic irq_ack_i,
	input wire wvip_pkg::wvip_grant_t grant_o
);
	import wvip_pkg::*;
	localparam logic [4:0] VIDX [8] = '{5'h1f, 5'h17, 5'h16, 5'h15,
		5'h14, 5'h1e, 5'h1d, 5'h01};

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	a_rd_slot: assert property (
		!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside its slot");
	a_freeze_cause: assert property (
		freeze_o |-> $past(pix_req_i.valid))
		else $error("freeze without pixel attempt");
	a_line_abort: assert property (
		line_abort_o |-> freeze_o && $past(pix_req_i.op) == WVIP_OP_LINE)
		else $error("abort without faulting line pixel");
	a_write_cause: assert property (
		pix_write_o |-> $past(pix_req_i.valid))
		else $error("pixel write without attempt");
	a_outside_hold: assert property (
		!$past(pix_req_i.valid) |-> $stable(window_outside_o))
		else $error("outside flag moved without attempt");
	a_cmp_done: assert property (
		cmp_done_o == $past(cmp_valid_i))
		else $error("compare done not one cycle after request");
	a_vec_map: assert property (
		grant_o.take |->
		grant_o.vector == WVIP_VEC_BASE + {22'h0, VIDX[grant_o.source], 5'h0})
		else $error("vector does not match source");
	a_grant_hold: assert property (
		grant_o.take && !irq_ack_i |=> grant_o.take && $stable(grant_o.source))
		else $error("offer dropped or changed before ack");
	a_ack_gap: assert property (
		grant_o.take && irq_ack_i |=> !grant_o.take [*2])
		else $error("no idle gap after ack");
	a_reset_offer: assert property (
		$rose(rst_b_i) |-> ##[1:2] grant_o.take && grant_o.source == 3'h0)
		else $error("reset not offered after release");
endmodule

bind wvip_top wvip_checker i_wvip_checker (.core_clk_i(core_clk_i),
	.rst_b_i(rst_b_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.pix_req_i(pix_req_i), .pix_write_o(pix_write_o),
	.line_abort_o(line_abort_o), .freeze_o(freeze_o),
	.window_outside_o(window_outside_o), .cmp_valid_i(cmp_valid_i),
	.cmp_done_o(cmp_done_o), .irq_ack_i(irq_ack_i), .grant_o(grant_o));

// ==== tb/tb_wvip_top.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_wvip_top;
	import wvip_pkg::*;
	logic clk = 0, rst_b = 0, wr = 0, rd = 0, pw, ab, fr, wo, cv = 0, cd;
	logic gie = 0, nmi = 0, host = 0, rast = 0, bad = 0, e1_b = 1, e2_b = 1;
	logic ack, slow = 0;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata, work = 32'h0, d;
	logic [15:0] cx = 16'h0, cy = 16'h0;
	logic [3:0] oc;
	wvip_pix_t pix = '0;
	wvip_grant_t gr;
	int failures = 0, tests_run = 0;
	logic [4:0] vidx [8] = '{5'h1f, 5'h17, 5'h16, 5'h15, 5'h14, 5'h1e,
		5'h1d, 5'h01};
	logic [2:0] ord [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
	logic [15:0] px_t [6] = '{16'h5, 16'h23, 16'hf, 16'hf, 16'h1e, 16'h5};
	logic [15:0] py_t [6] = '{16'h19, 16'h19, 16'ha, 16'h32, 16'h28, 16'ha};
	logic [3:0] oc_t [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'ha};

	always #5 clk = ~clk;

	wvip_top i_wvip_top (.core_clk_i(clk), .rst_b_i(rst_b),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .pix_req_i(pix), .work_state_i(work),
		.pix_write_o(pw), .line_abort_o(ab), .freeze_o(fr),
		.window_outside_o(wo), .cmp_valid_i(cv), .cmp_x_i(cx), .cmp_y_i(cy),
		.cmp_done_o(cd), .outcode_o(oc), .global_irq_enable_i(gie),
		.nmi_set_i(nmi), .host_request_irq_i(host), .raster_row_irq_i(rast),
		.ext_request_one_b_i(e1_b), .ext_request_two_b_i(e2_b),
		.bad_opcode_trap_i(bad), .irq_ack_i(ack), .grant_o(gr));
	wvip_core_model i_wvip_core_model (.core_clk_i(clk), .rst_b_i(rst_b),
		.take_i(gr.take), .slow_i(slow), .irq_ack_o(ack));

	// ------------------------------------------------------------
	// bus, pixel and grant-wait helpers
	// ------------------------------------------------------------
	task wrr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task pxl(input wvip_op_t op, input logic [15:0] x, input logic [15:0] y);
		@(posedge clk);
		pix <= {1'b1, op, x, y};
		work <= {x, y};
		@(posedge clk);
		pix.valid <= 1'b0;
		#1;
	endtask
	task wt(input logic want);
		int n;
		n = 0;
		while (gr.take !== want && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(gr.take, want)
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		wt(1'b1);
		`CHK(gr.source, 3'h0)
		`CHK(gr.vector, 32'hffffffe0)
		wt(1'b0);
	endtask
	task t_regs;
		wrr(WVIP_OFF_IRQ_EN, 32'hffffffff);
		rdr(WVIP_OFF_IRQ_EN);
		`CHK(d, WVIP_EN_MASK)
		rdr(8'h20);
		`CHK(d, 32'h0)
		rdr(WVIP_OFF_PEND);
		`CHK(d, 32'h0)
		wrr(WVIP_OFF_IRQ_EN, 32'h0);
		wrr(WVIP_OFF_WIN_START, 32'h0014000a);
		wrr(WVIP_OFF_WIN_END, 32'h0028001e);
	endtask
	task t_hit;
		wrr(WVIP_OFF_CTRL, 32'h1);
		pxl(WVIP_OP_BLOCK, 16'ha, 16'h28);
		`CHK({pw, ab, fr, wo}, 4'b0010)
		rdr(WVIP_OFF_PEND);
		`CHK(d[11], 1'b1)
		pxl(WVIP_OP_BLOCK, 16'h9, 16'h14);
		`CHK({pw, ab, fr, wo}, 4'b0001)
		rdr(WVIP_OFF_PEND);
		`CHK(d[11], 1'b1)
		wrr(WVIP_OFF_PEND, 32'h800);
		rdr(WVIP_OFF_PEND);
		`CHK(d[11], 1'b0)
	endtask
	task t_miss;
		wrr(WVIP_OFF_CTRL, 32'h2);
		pxl(WVIP_OP_LINE, 16'h1f, 16'h28);
		`CHK({pw, ab, fr, wo}, 4'b0111)
		`CHK(gr.take, 1'b0)
		rdr(WVIP_OFF_SNAP);
		`CHK(d, 32'h001f0028)
		rdr(WVIP_OFF_STATUS);
		`CHK(d[0], 1'b1)
		rdr(WVIP_OFF_PEND);
		`CHK(d[11], 1'b1)
		pxl(WVIP_OP_LINE, 16'h1e, 16'h28);
		`CHK({pw, ab, fr, wo}, 4'b1000)
		wrr(WVIP_OFF_PEND, 32'h800);
	endtask
	task t_clip;
		wrr(WVIP_OFF_CTRL, 32'h3);
		@(posedge clk);
		pix <= {1'b1, WVIP_OP_LINE, 16'h0, 16'h14};
		@(posedge clk);
		pix <= {1'b1, WVIP_OP_LINE, 16'ha, 16'h14};
		#1 `CHK({pw, ab, fr, wo}, 4'b0001)
		@(posedge clk);
		pix.valid <= 1'b0;
		#1 `CHK({pw, ab, fr, wo}, 4'b1000)
		rdr(WVIP_OFF_PEND);
		`CHK(d[11], 1'b0)
	endtask
	task t_cmp;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			cv <= 1'b1;
			cx <= px_t[i];
			cy <= py_t[i];
			@(posedge clk);
			cv <= 1'b0;
			#1 `CHK({cd, oc}, {1'b1, oc_t[i]})
		end
		rdr(WVIP_OFF_STATUS);
		`CHK(d[5:2], 4'ha)
	endtask
	task t_irq;
		slow <= 1'b1;
		wrr(WVIP_OFF_IRQ_EN, 32'h800);
		wrr(WVIP_OFF_CTRL, 32'h1);
		pxl(WVIP_OP_BLOCK, 16'hf, 16'h19);
		repeat (6) @(posedge clk);
		#1 `CHK(gr.take, 1'b0)
		@(posedge clk);
		gie <= 1'b1;
		wt(1'b1);
		`CHK(gr.source, 3'h4)
		`CHK(gr.vector, 32'hfffffe80)
		wrr(WVIP_OFF_PEND, 32'h800);
		wt(1'b0);
		rdr(WVIP_OFF_GRANT);
		`CHK(d, 32'hfffffe80)
		wrr(WVIP_OFF_CTRL, 32'h0);
		pxl(WVIP_OP_LINE, 16'h0, 16'h0);
		`CHK({pw, ab, fr, wo}, 4'b1000)
	endtask
	task t_prio;
		wrr(WVIP_OFF_IRQ_EN, 32'h00000e06);
		@(posedge clk);
		{nmi, host, rast, bad, e1_b, e2_b} <= 6'b111100;
		@(posedge clk);
		{nmi, host, rast, bad} <= 4'b0000;
		for (int i = 0; i < 6; i++) begin
			wt(1'b1);
			`CHK(gr.source, ord[i])
			`CHK(gr.vector, WVIP_VEC_BASE + {22'h0, vidx[ord[i]], 5'h0})
			@(posedge clk);
			if (ord[i] == 3'h2) wrr(WVIP_OFF_PEND, 32'h200);
			if (ord[i] == 3'h3) wrr(WVIP_OFF_PEND, 32'h400);
			if (ord[i] == 3'h5) e1_b <= 1'b1;
			if (ord[i] == 3'h6) e2_b <= 1'b1;
			wt(1'b0);
		end
	endtask

	task results;
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#200000;
		failures++;
		results;
	end

	initial begin
		t_reset;
		t_regs;
		t_hit;
		t_miss;
		t_clip;
		t_cmp;
		t_irq;
		t_prio;
		results;
	end
endmodule
